//--- logic/ivm_pkg.sv
package ivm_pkg;
    localparam int VEC_N  = 65;
    localparam int VEC_W  = 7;
    localparam int ADDR_W = 8;
    localparam int SPLIT_N = 5;

    // vector numbers that logic or checks refer to
    localparam int VEC_BROWNOUT     = 2;
    localparam int VEC_CLK_FAIL     = 3;
    localparam int VEC_RTC_OVF_CMP  = 5;
    localparam int VEC_PERIODIC     = 6;
    localparam int VEC_CUSTOM_LOGIC = 7;
    localparam int VEC_TA0_BASE     = 9;
    localparam int VEC_TA1_BASE     = 47;
    localparam int TA_HUNF_OFS      = 1;
    localparam int VEC_SER0_RECV    = 21;
    localparam int VEC_ADC_READY    = 26;
    localparam int VEC_ADC_WINDOW   = 27;
    localparam int VEC_EEPROM_RDY   = 36;

    // reset and non-maskable slots carry no flag here
    localparam logic [VEC_N-1:0] VEC_MASKABLE = {{(VEC_N-2){1'b1}}, 2'h0};

    // apb register byte offsets
    localparam logic [7:0] REG_FLAG0  = 8'h00;
    localparam logic [7:0] REG_FLAG1  = 8'h04;
    localparam logic [7:0] REG_FLAG2  = 8'h08;
    localparam logic [7:0] REG_EN0    = 8'h10;
    localparam logic [7:0] REG_EN1    = 8'h14;
    localparam logic [7:0] REG_EN2    = 8'h18;
    localparam logic [7:0] REG_CTRL   = 8'h20;
    localparam logic [7:0] REG_STATUS = 8'h24;

    localparam int CTRL_GIE_BIT    = 0;
    localparam int CTRL_SPLIT0_BIT = 1;
    localparam int CTRL_SPLIT1_BIT = 2;
    localparam int CTRL_W          = 3;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;

    localparam int STAT_VEC_LSB   = 0;
    localparam int STAT_VALID_BIT = 8;
    localparam int STAT_ADDR_LSB  = 16;
endpackage

//--- logic/ivm_vector_ctrl.sv
`timescale 1ns/10ps
module ivm_vector_ctrl
    import ivm_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               arst_n,
    input  wire logic [7:0]         paddr,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [31:0]        pwdata,
    input  wire logic [3:0]         pstrb,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic [VEC_N-1:0]   periphEvent,
    input  wire logic               rtcCompareEvent,
    input  wire logic [SPLIT_N-1:0] splitEvent0,
    input  wire logic [SPLIT_N-1:0] splitEvent1,
    output logic                    irq,
    output logic      [VEC_W-1:0]   irqVector,
    output logic      [ADDR_W-1:0]  irqWordAddr
);

    logic [VEC_N-1:0]  flag_r;
    logic [VEC_N-1:0]  en_r;
    logic [CTRL_W-1:0] ctrl_r;
    logic [31:0]       prdata_r;
    logic              pready_r;
    logic              pslverr_r;
    logic              irq_r;
    logic [VEC_W-1:0]  irqVector_r;
    logic [ADDR_W-1:0] irqWordAddr_r;

    // events routed onto vector slots; the table is fixed except the timer slots, which the split-mode control bits reroute
    function automatic logic [VEC_N-1:0] mapEvents(
        input logic [VEC_N-1:0]   ev,
        input logic               rtcCmp,
        input logic [SPLIT_N-1:0] sp0,
        input logic [SPLIT_N-1:0] sp1,
        input logic               mode0,
        input logic               mode1
    );
        logic [VEC_N-1:0] m;
        m = ev & VEC_MASKABLE;
        m[VEC_RTC_OVF_CMP] = ev[VEC_RTC_OVF_CMP] | rtcCmp;
        for (int k = 0; k < SPLIT_N; k++)
        begin
            if (mode0)
                m[VEC_TA0_BASE+k] = sp0[k];
            if (mode1)
                m[VEC_TA1_BASE+k] = sp1[k];
        end
        if (!mode0)
            m[VEC_TA0_BASE+TA_HUNF_OFS] = 1'b0;
        if (!mode1)
            m[VEC_TA1_BASE+TA_HUNF_OFS] = 1'b0;
        return m;
    endfunction

    // lowest vector number wins when several requests are pending
    function automatic logic [VEC_W-1:0] pickLowest(input logic [VEC_N-1:0] r);
        logic [VEC_W-1:0] v;
        v = '0;
        for (int i = VEC_N - 1; i >= 0; i--)
        begin
            if (r[i])
                v = VEC_W'(i);
        end
        return v;
    endfunction

    function automatic logic [ADDR_W-1:0] vecToAddr(input logic [VEC_W-1:0] v);
        return {v, 1'b0};
    endfunction

    function automatic logic [31:0] byteMask(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    // bus decode
    wire        accessPhase = psel & penable;
    wire        answerNow   = accessPhase & ~pready_r;
    wire        xferDone    = accessPhase & pready_r;
    wire        selFlag0    = (paddr == REG_FLAG0);
    wire        selFlag1    = (paddr == REG_FLAG1);
    wire        selFlag2    = (paddr == REG_FLAG2);
    wire        selEn0      = (paddr == REG_EN0);
    wire        selEn1      = (paddr == REG_EN1);
    wire        selEn2      = (paddr == REG_EN2);
    wire        selCtrl     = (paddr == REG_CTRL);
    wire        selStatus   = (paddr == REG_STATUS);
    wire        mapped      = selFlag0 | selFlag1 | selFlag2 | selEn0 | selEn1 | selEn2 | selCtrl | selStatus;
    wire        wrEn        = xferDone & pwrite & mapped;
    wire [31:0] wMask       = byteMask(pstrb);
    wire [31:0] wBits       = pwdata & wMask;

    // control fields
    wire        globalEn  = ctrl_r[CTRL_GIE_BIT];
    wire        splitMode0 = ctrl_r[CTRL_SPLIT0_BIT];
    wire        splitMode1 = ctrl_r[CTRL_SPLIT1_BIT];

    // flag write-one-to-clear
    wire [31:0]      clr0   = (wrEn & selFlag0) ? wBits : 32'h0;
    wire [31:0]      clr1   = (wrEn & selFlag1) ? wBits : 32'h0;
    wire [31:0]      clr2   = (wrEn & selFlag2) ? wBits : 32'h0;
    wire [VEC_N-1:0] clrAll = {clr2[0], clr1, clr0};

    wire [VEC_N-1:0] evtMapped = mapEvents(periphEvent, rtcCompareEvent, splitEvent0, splitEvent1,
                                           splitMode0, splitMode1);

    // set wins over a clear landing in the same cycle; flags ignore enables
    wire [VEC_N-1:0] flag_nxt = ((flag_r & ~clrAll) | evtMapped) & VEC_MASKABLE;

    // enable words, byte-strobed
    wire [31:0]      enMask0 = (wrEn & selEn0) ? wMask : 32'h0;
    wire [31:0]      enMask1 = (wrEn & selEn1) ? wMask : 32'h0;
    wire [31:0]      enMask2 = (wrEn & selEn2) ? wMask : 32'h0;
    wire [VEC_N-1:0] enMaskAll = {enMask2[0], enMask1, enMask0};
    wire [VEC_N-1:0] enWrData  = {pwdata[0], pwdata, pwdata};
    wire [VEC_N-1:0] en_nxt    = ((en_r & ~enMaskAll) | (enWrData & enMaskAll)) & VEC_MASKABLE;

    wire [CTRL_W-1:0] ctrlMask = (wrEn & selCtrl) ? wMask[CTRL_W-1:0] : '0;
    wire [CTRL_W-1:0] ctrl_nxt = (ctrl_r & ~ctrlMask) | (pwdata[CTRL_W-1:0] & ctrlMask);

    // request generation
    wire [VEC_N-1:0]  reqVec  = flag_r & en_r & {VEC_N{globalEn}};
    wire              pending = |reqVec;
    wire [VEC_W-1:0]  lowest  = pickLowest(reqVec);

    wire              irq_nxt         = pending;
    wire [VEC_W-1:0]  irqVector_nxt   = pending ? lowest : '0;
    wire [ADDR_W-1:0] irqWordAddr_nxt = vecToAddr(irqVector_nxt);

    // read mux
    logic [31:0] statusWord;
    always_comb
    begin
        statusWord = 32'h0;
        statusWord[STAT_VEC_LSB +: VEC_W]   = irqVector_r;
        statusWord[STAT_VALID_BIT]          = irq_r;
        statusWord[STAT_ADDR_LSB +: ADDR_W] = irqWordAddr_r;
    end

    wire [31:0] rdWord = selFlag0  ? flag_r[31:0]  :
                         selFlag1  ? flag_r[63:32] :
                         selFlag2  ? {31'h0, flag_r[VEC_N-1]} :
                         selEn0    ? en_r[31:0] :
                         selEn1    ? en_r[63:32] :
                         selEn2    ? {31'h0, en_r[VEC_N-1]} :
                         selCtrl   ? {29'h0, ctrl_r} :
                         selStatus ? statusWord : 32'h0;

    wire [31:0] prdata_nxt  = (answerNow & ~pwrite) ? rdWord : prdata_r;
    wire        pready_nxt  = answerNow;
    wire        pslverr_nxt = answerNow & ~mapped;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            flag_r <= '0;
            en_r   <= '0;
            ctrl_r <= CTRL_RESET;
        end
        else
        begin
            flag_r <= flag_nxt;
            en_r   <= en_nxt;
            ctrl_r <= ctrl_nxt;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prdata_r  <= 32'h0;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // registered so the core sees a glitch-free vector with its request
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq_r         <= 1'b0;
            irqVector_r   <= '0;
            irqWordAddr_r <= '0;
        end
        else
        begin
            irq_r         <= irq_nxt;
            irqVector_r   <= irqVector_nxt;
            irqWordAddr_r <= irqWordAddr_nxt;
        end
    end

    assign prdata      = prdata_r;
    assign pready      = pready_r;
    assign pslverr     = pslverr_r;
    assign irq         = irq_r;
    assign irqVector   = irqVector_r;
    assign irqWordAddr = irqWordAddr_r;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    sequence evtSeen;
        (evtMapped != '0);
    endsequence

    sequence noReqChange;
        !wrEn ##1 !wrEn;
    endsequence

    // helper terms so that $past only ever sees a plain signal
    wire             flagEnHit = |(flag_r & en_r);
    wire [VEC_N-1:0] clashHit  = clrAll & evtMapped;

    sequence clrOnly;
        (clrAll != '0) && (clashHit == '0);
    endsequence

    sequence setOverClr;
        (clashHit != '0);
    endsequence

    sequence twoPending;
        reqVec[VEC_BROWNOUT] && reqVec[VEC_EEPROM_RDY];
    endsequence

    sequence periodicAlone;
        periphEvent[VEC_PERIODIC] && !periphEvent[VEC_RTC_OVF_CMP] && !rtcCompareEvent;
    endsequence

    chk_flag_ignores_enable: assert property (evtSeen |=> ((flag_r & $past(evtMapped)) == $past(evtMapped)))
        else $error("event did not set its flag");
    chk_enable_write_only: assert property (!wrEn |=> (en_r == $past(en_r)))
        else $error("enable changed without a write");
    chk_req_needs_pair: assert property (irq |-> $past(flagEnHit))
        else $error("request without flag and enable");
    chk_global_gate_off: assert property (!globalEn |=> !irq)
        else $error("request while globally disabled");
    chk_req_holds_on: assert property ((irq && pending) ##0 noReqChange |=> irq)
        else $error("request dropped without a flag clear");
    chk_addr_twice_vec: assert property (irq |-> (irqWordAddr == ADDR_W'(2 * irqVector) && irqVector >= VEC_W'(2)))
        else $error("vector address is not twice the vector");
    chk_rtc_vec_shared: assert property (rtcCompareEvent |=> flag_r[VEC_RTC_OVF_CMP])
        else $error("compare match missed the shared counter vector");
    chk_normal_hunf_idle: assert property ((!splitMode0 && !flag_r[VEC_TA0_BASE+TA_HUNF_OFS]) |=>
                                           !flag_r[VEC_TA0_BASE+TA_HUNF_OFS])
        else $error("unused vector raised in normal mode");
    chk_split_low_unf: assert property ((splitMode0 && splitEvent0[0]) |=> flag_r[VEC_TA0_BASE])
        else $error("split low underflow missed its vector");
    chk_eeprom_vec_slot: assert property (periphEvent[VEC_EEPROM_RDY] |=> flag_r[VEC_EEPROM_RDY])
        else $error("eeprom ready missed its vector");
    chk_apb_one_wait: assert property ((psel && penable && !pready) |=> pready)
        else $error("apb answer late");

    // fixed slots: each source must land on its own table entry, except counter overflow and compare match, which share one
    chk_brownout_slot: assert property (periphEvent[VEC_BROWNOUT]
                                        |=> flag_r[VEC_BROWNOUT])
        else $error("brown-out event missed its vector");

    chk_clkfail_slot: assert property (periphEvent[VEC_CLK_FAIL]
                                       |=> flag_r[VEC_CLK_FAIL])
        else $error("clock failure event missed its vector");

    chk_rtc_ovf_slot: assert property (periphEvent[VEC_RTC_OVF_CMP]
                                       |=> flag_r[VEC_RTC_OVF_CMP])
        else $error("counter overflow missed the shared vector");

    // periodic tick must never leak onto the shared counter slot
    chk_periodic_own: assert property ((periodicAlone and !flag_r[VEC_RTC_OVF_CMP])
                                       |=> (flag_r[VEC_PERIODIC] && !flag_r[VEC_RTC_OVF_CMP]))
        else $error("periodic tick not on its own vector");

    chk_custom_slot: assert property (periphEvent[VEC_CUSTOM_LOGIC]
                                      |=> flag_r[VEC_CUSTOM_LOGIC])
        else $error("custom logic event missed its vector");

    chk_normal_ovf_slot: assert property ((!splitMode0 && periphEvent[VEC_TA0_BASE])
                                          |=> flag_r[VEC_TA0_BASE])
        else $error("timer overflow missed its vector");

    chk_split_high_unf: assert property ((splitMode0 && splitEvent0[TA_HUNF_OFS])
                                         |=> flag_r[VEC_TA0_BASE+TA_HUNF_OFS])
        else $error("split high underflow missed its vector");

    chk_normal1_hunf_idle: assert property ((!splitMode1 && !flag_r[VEC_TA1_BASE+TA_HUNF_OFS])
                                            |=> !flag_r[VEC_TA1_BASE+TA_HUNF_OFS])
        else $error("unused second timer vector raised");

    chk_split1_low_unf: assert property ((splitMode1 && splitEvent1[0])
                                         |=> flag_r[VEC_TA1_BASE])
        else $error("second timer low underflow missed its vector");

    chk_split_cmp_slot: assert property ((splitMode0 && splitEvent0[SPLIT_N-1])
                                         |=> flag_r[VEC_TA0_BASE+SPLIT_N-1])
        else $error("split low compare missed its vector");

    chk_normal_cmp_slot: assert property ((!splitMode0 && periphEvent[VEC_TA0_BASE+SPLIT_N-1])
                                          |=> flag_r[VEC_TA0_BASE+SPLIT_N-1])
        else $error("full compare missed its vector");

    chk_serial_recv_slot: assert property (periphEvent[VEC_SER0_RECV]
                                           |=> flag_r[VEC_SER0_RECV])
        else $error("receive complete missed its vector");

    chk_serial_xmit_slot: assert property (periphEvent[VEC_SER0_RECV+2]
                                           |=> flag_r[VEC_SER0_RECV+2])
        else $error("transmit complete missed its vector");

    chk_adc_ready_slot: assert property (periphEvent[VEC_ADC_READY]
                                         |=> flag_r[VEC_ADC_READY])
        else $error("result ready missed its vector");

    chk_adc_window_slot: assert property (periphEvent[VEC_ADC_WINDOW]
                                          |=> flag_r[VEC_ADC_WINDOW])
        else $error("window compare missed its vector");

    // clear and set interplay: a lone clear drops, a clash keeps the flag
    chk_w1c_clears: assert property (clrOnly
                                     |=> ((flag_r & $past(clrAll)) == '0))
        else $error("write one did not clear the flag");

    chk_set_beats_clear: assert property (setOverClr
                                          |=> ((flag_r & $past(clashHit)) == $past(clashHit)))
        else $error("clear won over a same-cycle event");

    chk_req_needs_global: assert property (irq
                                           |-> $past(globalEn))
        else $error("request without global enable");

    chk_ctrl_write_only: assert property (!(wrEn && selCtrl)
                                          |=> (ctrl_r == $past(ctrl_r)))
        else $error("control changed without a write");

    chk_no_req_idle: assert property ((reqVec == '0)
                                      |=> !irq)
        else $error("request with nothing pending");

    chk_vector_idle_zero: assert property (!irq
                                           |-> (irqVector == '0 && irqWordAddr == '0))
        else $error("vector shown without a request");

    // priority is a local choice: the lower slot is offered first
    chk_lowest_first: assert property (twoPending
                                       |=> (irqVector == VEC_W'(VEC_BROWNOUT)))
        else $error("lower vector not offered first");

    chk_apb_err_unmapped: assert property ((psel && penable && !pready && !mapped)
                                           |=> pslverr)
        else $error("unmapped access without error");

    chk_apb_err_quiet: assert property ((psel && penable && !pready && mapped)
                                        |=> !pslverr)
        else $error("error on a mapped access");

endmodule // ivm_vector_ctrl

//--- verification/ivm_cpu_fetch.sv
`timescale 1ns/10ps
module ivm_cpu_fetch
    import ivm_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire logic              irq,
    input  wire logic [ADDR_W-1:0] irqWordAddr,
    output logic      [ADDR_W-1:0] fetchAddr
);
    logic irqSeen_r;
    // one fetch per new request; a held request is not fetched twice
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irqSeen_r <= 1'b0;
            fetchAddr <= '0;
        end
        else
        begin
            irqSeen_r <= irq;
            if (irq && !irqSeen_r)
                fetchAddr <= irqWordAddr;
        end
    end
endmodule // ivm_cpu_fetch

//--- verification/interrupt_vector_mapping_tb_top.sv
`timescale 1ns/10ps
module interrupt_vector_mapping_tb_top
    import ivm_pkg::*;
;
    logic               clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]         paddr = 0;
    logic [31:0]        pwdata = 0, prdata;
    logic               pready, pslverr, irq, rtcCompareEvent = 0;
    logic [VEC_N-1:0]   periphEvent = '0;
    logic [SPLIT_N-1:0] splitEvent0 = '0, splitEvent1 = '0;
    logic [VEC_W-1:0]   irqVector;
    logic [ADDR_W-1:0]  irqWordAddr, fetchAddr;
    logic [31:0]        rdv;
    logic               rde;
    int                 err_total = 0, n_compared = 0;
    int                 vecs[16] = '{2, 3, 5, 6, 7, 9, 11, 12, 13, 21, 22, 23, 26, 27, 36, 64};

    ivm_vector_ctrl i_dut (.clk(clk), .arst_n(arst_n), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .periphEvent(periphEvent), .rtcCompareEvent(rtcCompareEvent), .splitEvent0(splitEvent0),
        .splitEvent1(splitEvent1), .irq(irq), .irqVector(irqVector), .irqWordAddr(irqWordAddr));
    ivm_cpu_fetch i_cpu (.clk(clk), .arst_n(arst_n), .irq(irq), .irqWordAddr(irqWordAddr),
        .fetchAddr(fetchAddr));

    always #5 clk = ~clk;

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // request held until pready is sampled high; no wait count assumed
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1; penable <= 0; paddr <= a; pwrite <= w; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50) chk("pready", 1, 0);
        rdv = prdata;
        rde = pslverr;
        psel <= 0; penable <= 0;
    endtask

    task automatic pulse(input logic [VEC_N-1:0] p, input logic r, input logic [4:0] s);
        @(posedge clk);
        periphEvent <= p; rtcCompareEvent <= r; splitEvent0 <= s; splitEvent1 <= s;
        @(posedge clk);
        periphEvent <= '0; rtcCompareEvent <= 0; splitEvent0 <= '0; splitEvent1 <= '0;
        @(posedge clk);
        #1;
    endtask

    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic vec_ok(input int v);
        chk("irq", 1, irq);
        chk("irqVector", v, irqVector);
        chk("irqWordAddr", 2 * v, irqWordAddr);
        @(posedge clk);
        #1;
        chk("fetchAddr", 2 * v, fetchAddr);
        apb(REG_FLAG0, 1, '1);
        apb(REG_FLAG1, 1, '1);
        apb(REG_FLAG2, 1, '1);
    endtask

    task automatic t_gating();
        apb(REG_CTRL, 0, 0);
        chk("ctrl reset", 0, rdv);
        pulse(65'h1 << 36, 0, 0);
        chk("irq no enable", 0, irq);
        apb(REG_FLAG1, 0, 0);
        chk("flag 36", 32'h10, rdv);
        apb(REG_EN1, 1, 32'h10);
        settle();
        chk("irq no global", 0, irq);
        apb(REG_CTRL, 1, 1);
        settle();
        chk("irqVector", 36, irqVector);
        repeat (20) @(posedge clk);
        #1;
        chk("irq held", 1, irq);
        apb(REG_STATUS, 0, 0);
        chk("status", 32'h00480124, rdv);
        apb(REG_EN1, 1, 0);
        settle();
        chk("irq disabled", 0, irq);
        apb(REG_EN1, 1, 32'h10);
        settle();
        vec_ok(36);
        settle();
        chk("irq cleared", 0, irq);
    endtask

    task automatic t_table();
        apb(REG_EN0, 1, '1);
        apb(REG_EN1, 1, '1);
        apb(REG_EN2, 1, 1);
        foreach (vecs[i])
        begin
            pulse(65'h1 << vecs[i], 0, 0);
            vec_ok(vecs[i]);
        end
        pulse(0, 1, 0);
        vec_ok(5);
        pulse(65'h1 << 10, 0, 0);
        chk("v10 normal", 0, irq);
    endtask

    task automatic t_split();
        apb(REG_CTRL, 1, 3);
        pulse(0, 0, 5'h02);
        vec_ok(10);
        pulse(0, 0, 5'h01);
        vec_ok(9);
        pulse(0, 0, 5'h10);
        vec_ok(13);
        apb(REG_CTRL, 1, 5);
        pulse(0, 0, 5'h02);
        vec_ok(48);
        apb(8'h30, 0, 0);
        chk("unmapped err", 1, rde);
        chk("unmapped data", 0, rdv);
    endtask

    // reset in mid-run with a request standing
    task automatic t_reset();
        pulse(65'h1 << 36, 0, 0);
        chk("irq before reset", 1, irq);
        arst_n <= 0;
        @(posedge clk);
        #1;
        chk("irq in reset", 0, irq);
        chk("vector in reset", 0, irqVector);
        repeat (2) @(posedge clk);
        arst_n <= 1;
        @(posedge clk);
        #1;
        chk("irq after reset", 0, irq);
        apb(REG_CTRL, 0, 0);
        chk("ctrl after reset", 0, rdv);
        apb(REG_EN1, 0, 0);
        chk("enable after reset", 0, rdv);
    endtask

    initial
    begin
        repeat (6) @(posedge clk);
        arst_n <= 1;
        t_gating();
        t_table();
        t_split();
        t_reset();
        end_of_test();
    end

    initial
    begin
        #500000;
        err_total++;
        end_of_test();
    end
endmodule // interrupt_vector_mapping_tb_top
